// [rtl/config_word_decoder.sv]
// configuration word store, programmer port over AHB-Lite, decoded mode outputs
// assumes the AHB master is the programmer; progMode comes from a pin
`timescale 1ns/1ps
`include "config_word_params.svh"
// Function
// - two-bit protect field: 11 off, 00 all
// - single protect bit: 1 off, 0 on
// - data protect bit 0 protects EEPROM
// - brownout enable bit gates brownout reset
// - brownout enabled forces power-up timer on
// - power-up timer bit active low
// - reset pin select: 1 reset, 0 IO
// - watchdog enable bit gates watchdog
// - two-bit oscillator field decode
// - three-bit oscillator field decode, 011 reserved
// - unimplemented word bits read as one
// - running program cannot read configuration
// - unprotected memory readable by programmer
// - masked parts: data protect follows program protect
// - full EEPROM erase clears data protection
// - four user IDs at 2000h-2003h, program mode
// - word at 2007h, program mode only
// - programmed bit reads zero; powerup state used
module config_word_decoder #(
	parameter bit SINGLE_CP_BIT = 1'b0,
	parameter bit OSC_3BIT = 1'b1,
	parameter bit MASKED_ROM = 1'b0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// mode pin, asynchronous
	input wire logic progModePin,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// decoded settings
	output config_word_pkg::cp_level_t codeProtectLevel,
	output logic programReadAllowed,
	output logic dataEepromProtect,
	output logic brownoutResetEn,
	output logic powerupTimerEn,
	output logic resetPinIsReset,
	output logic watchdogEn,
	output config_word_pkg::osc_mode_t oscMode
);
	import config_word_pkg::*;

	// synchroniser
	logic progSync1_r;
	logic progSync2_r;
	// non-volatile store, erased at power-up of the model
	logic [13:0] cfgWord_r = `CFG_WORD_ERASED;
	logic [13:0] cfgWord_nxt;
	logic [13:0] uidRd [4];
	logic dpCleared_r = 1'b0;
	logic dpCleared_nxt;
	// bus
	logic wrPend_r;
	logic wrPend_nxt;
	logic [7:0] wrAddr_r;
	logic [7:0] wrAddr_nxt;
	logic [31:0] hrdata_nxt;
	logic hreadyout_nxt;
	logic hresp_nxt;
	// loader state and outputs
	load_state_t ldState_r;
	load_state_t ldState_nxt;
	cp_level_t cpLvl_r;
	cp_level_t cpLvl_nxt;
	logic readOk_r;
	logic readOk_nxt;
	logic dpOut_r;
	logic dpOut_nxt;
	logic borOut_r;
	logic borOut_nxt;
	logic pwrtOut_r;
	logic pwrtOut_nxt;
	logic rstPinOut_r;
	logic rstPinOut_nxt;
	logic wdtOut_r;
	logic wdtOut_nxt;
	osc_mode_t osc_r;
	osc_mode_t osc_nxt;
	logic addrPhase;
	logic storeWr;
	logic isCtrl;
	logic isCfg;
	logic isUid;
	// decode
	logic [1:0] cpRaw;
	logic [2:0] oscRaw;
	logic [2:0] osc2Map;
	cp_level_t decCp;
	logic decReadOk;
	logic decDp;
	logic decBor;
	logic decPwrt;
	logic decRstPin;
	logic decWdt;
	osc_mode_t decOsc;

	// pin synchroniser
	// only the second stage is read; the first may be metastable
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			progSync1_r <= 1'b0;
			progSync2_r <= 1'b0;
		end else begin
			progSync1_r <= progModePin;
			progSync2_r <= progSync1_r;
		end
	end

	assign addrPhase = hsel && hready && htrans[1];
	assign storeWr = wrPend_r && progSync2_r;
	assign isCtrl = (wrAddr_r == `AHB_OFF_CTRL);
	assign isCfg = (wrAddr_r == `AHB_OFF_CFG);
	assign isUid = (wrAddr_r[7:4] == 4'h1) && (wrAddr_r[1:0] == 2'b00);

	// programmer read path and write capture
	always_comb begin
		wrPend_nxt = 1'b0;
		wrAddr_nxt = wrAddr_r;
		hrdata_nxt = hrdata;
		if (addrPhase) begin
			wrPend_nxt = hwrite;
			wrAddr_nxt = haddr[7:0];
			hrdata_nxt = 32'h0;
			if (!hwrite && progSync2_r) begin
				if (haddr[7:0] == `AHB_OFF_CFG) begin
					hrdata_nxt = {18'h0, cfgWord_r};
				end else if (haddr[7:0] == `AHB_OFF_STATUS) begin
					hrdata_nxt = {29'h0, dpCleared_r, readOk_r, progSync2_r};
				end else if (haddr[7:4] == 4'h1 && haddr[1:0] == 2'b00) begin
					hrdata_nxt = {18'h0, uidRd[haddr[3:2]]};
				end
			end
		end
	end

	// single-cycle slave: no wait states, always okay
	always_comb begin
		hreadyout_nxt = 1'b1;
		hresp_nxt = 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wrPend_r <= wrPend_nxt;
			wrAddr_r <= wrAddr_nxt;
			hrdata <= hrdata_nxt;
			hreadyout <= hreadyout_nxt;
			hresp <= hresp_nxt;
		end
	end

	// store and erase flag, written only in program mode
	always_comb begin
		cfgWord_nxt = cfgWord_r;
		dpCleared_nxt = dpCleared_r;
		if (storeWr && isCtrl && hwdata[0]) begin
			dpCleared_nxt = 1'b1;
		end else if (storeWr && isCfg) begin
			cfgWord_nxt = hwdata[13:0] | ~`CFG_IMPL_MASK;
			// a new word re-arms data protection
			dpCleared_nxt = 1'b0;
		end
	end

	// non-volatile store survives reset
	always_ff @(posedge sys_clk) begin
		cfgWord_r <= cfgWord_nxt;
		dpCleared_r <= dpCleared_nxt;
	end

	// per-entry user id store, never reset
	for (genvar g = 0; g < 4; g++) begin : gUid
		logic [13:0] idWord_r = `UID_RESET;
		logic [13:0] idWord_nxt;
		always_comb begin
			idWord_nxt = idWord_r;
			if (storeWr && isUid && wrAddr_r[3:2] == 2'(g)) begin
				idWord_nxt = hwdata[13:0];
			end
		end
		always_ff @(posedge sys_clk) begin
			idWord_r <= idWord_nxt;
		end
		assign uidRd[g] = idWord_r;
	end

	// decode, captured once after reset release
	// protect field, widened when only one bit exists
	assign cpRaw = SINGLE_CP_BIT ? {2{cfgWord_r[`CFG_CP0_BIT]}} : cfgWord_r[`CFG_CP1_BIT:`CFG_CP0_BIT];

	// two-bit field maps onto the three-bit codes
	always_comb begin
		unique case (cfgWord_r[`CFG_OSC_LSB+1:`CFG_OSC_LSB])
			2'b11: osc2Map = OSC_RC;
			2'b10: osc2Map = OSC_HIGH_SPEED;
			2'b01: osc2Map = OSC_STANDARD;
			2'b00: osc2Map = OSC_LOW_POWER;
		endcase
	end
	assign oscRaw = OSC_3BIT ? cfgWord_r[`CFG_OSC_LSB+2:`CFG_OSC_LSB] : osc2Map;

	// settings as the stored word selects them
	always_comb begin
		decCp = cp_level_t'(cpRaw);
		decReadOk = (cpRaw == 2'b11);
		if (MASKED_ROM) begin
			decDp = (cpRaw != 2'b11);
		end else begin
			decDp = ~cfgWord_r[`CFG_DP_BIT] & ~dpCleared_r;
		end
		decBor = cfgWord_r[`CFG_BOR_BIT];
		decPwrt = cfgWord_r[`CFG_BOR_BIT] | ~cfgWord_r[`CFG_POWERUP_TIMER_BIT];
		decRstPin = cfgWord_r[`CFG_RESET_PIN_BIT];
		decWdt = cfgWord_r[`CFG_WDT_BIT];
		decOsc = osc_mode_t'(oscRaw);
	end

	// loader: one latch after reset release, then hold until next reset
	always_comb begin
		ldState_nxt = ldState_r;
		cpLvl_nxt = cpLvl_r;
		readOk_nxt = readOk_r;
		dpOut_nxt = dpOut_r;
		borOut_nxt = borOut_r;
		pwrtOut_nxt = pwrtOut_r;
		rstPinOut_nxt = rstPinOut_r;
		wdtOut_nxt = wdtOut_r;
		osc_nxt = osc_r;
		unique case (ldState_r)
			LD_IDLE: ldState_nxt = LD_LATCH;
			LD_LATCH: begin
				ldState_nxt = LD_HOLD;
				cpLvl_nxt = decCp;
				readOk_nxt = decReadOk;
				dpOut_nxt = decDp;
				borOut_nxt = decBor;
				pwrtOut_nxt = decPwrt;
				rstPinOut_nxt = decRstPin;
				wdtOut_nxt = decWdt;
				osc_nxt = decOsc;
			end
			LD_HOLD: ldState_nxt = LD_HOLD;
			default: ldState_nxt = LD_IDLE;
		endcase
	end

	// loader registers; reset gives the safe settings
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ldState_r <= LD_IDLE;
			cpLvl_r <= CP_ALL;
			readOk_r <= 1'b0;
			dpOut_r <= 1'b1;
			borOut_r <= 1'b0;
			pwrtOut_r <= 1'b1;
			rstPinOut_r <= 1'b1;
			wdtOut_r <= 1'b0;
			osc_r <= OSC_RC;
		end else begin
			ldState_r <= ldState_nxt;
			cpLvl_r <= cpLvl_nxt;
			readOk_r <= readOk_nxt;
			dpOut_r <= dpOut_nxt;
			borOut_r <= borOut_nxt;
			pwrtOut_r <= pwrtOut_nxt;
			rstPinOut_r <= rstPinOut_nxt;
			wdtOut_r <= wdtOut_nxt;
			osc_r <= osc_nxt;
		end
	end

	// outputs straight from the loader registers
	assign codeProtectLevel = cpLvl_r;
	assign programReadAllowed = readOk_r;
	assign dataEepromProtect = dpOut_r;
	assign brownoutResetEn = borOut_r;
	assign powerupTimerEn = pwrtOut_r;
	assign resetPinIsReset = rstPinOut_r;
	assign watchdogEn = wdtOut_r;
	assign oscMode = osc_r;
endmodule

// [common/config_word_params.svh]
// constants for the configuration word decoder
// assumes a 14-bit program word and a 14-bit-addressed programming port
`ifndef CONFIG_WORD_PARAMS_SVH
`define CONFIG_WORD_PARAMS_SVH
`define CFG_WORD_ADDR 14'h2007
`define USER_ID_BASE_ADDR 14'h2000
`define USER_ID_LAST_ADDR 14'h2003
`define CFG_WORD_ERASED 14'h3fff
`define CFG_OSC_LSB 0
`define CFG_WDT_BIT 3
`define CFG_POWERUP_TIMER_BIT 4
`define CFG_CP0_BIT 5
`define CFG_CP1_BIT 6
`define CFG_BOR_BIT 7
`define CFG_DP_BIT 8
`define CFG_RESET_PIN_BIT 9
`define CFG_IMPL_MASK 14'h03ff
`define AHB_OFF_CTRL 8'h00
`define AHB_OFF_STATUS 8'h04
`define AHB_OFF_CFG 8'h08
`define AHB_OFF_UID0 8'h10
`define UID_RESET 14'h3fff
`endif

// [common/config_word_pkg.sv]
// types shared by the configuration word decoder
// no assumptions beyond the params header
package config_word_pkg;
	typedef enum logic [2:0] {
		OSC_LOW_POWER = 3'b000,
		OSC_STANDARD = 3'b001,
		OSC_HIGH_SPEED = 3'b010,
		OSC_RESERVED = 3'b011,
		OSC_INTERNAL = 3'b100,
		OSC_INTERNAL_CLOCK_OUT_PIN = 3'b101,
		OSC_RC = 3'b110,
		OSC_RC_CLOCK_OUT_PIN = 3'b111
	} osc_mode_t;
	typedef enum logic [1:0] {
		CP_ALL = 2'b00,
		CP_PART_A = 2'b01,
		CP_PART_B = 2'b10,
		CP_OFF = 2'b11
	} cp_level_t;
	typedef enum logic [1:0] {
		LD_IDLE = 2'b00,
		LD_LATCH = 2'b01,
		LD_HOLD = 2'b10
	} load_state_t;
endpackage

// [dv/config_word_decoder_monitor.sv]
// port checker for the configuration word decoder
// assumes hsel high and single word transfers
`timescale 1ns/1ps
module config_word_decoder_monitor
	import config_word_pkg::*;
(
	// clock, reset, mode pin
	input wire logic sys_clk, reset_n, progModePin,
	// bus
	input wire logic hsel, hwrite, hready, hreadyout, hresp,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	input wire logic [31:0] haddr, hwdata, hrdata,
	// settings
	input wire cp_level_t codeProtectLevel,
	input wire logic programReadAllowed, dataEepromProtect, brownoutResetEn,
	input wire logic powerupTimerEn, resetPinIsReset, watchdogEn,
	input wire osc_mode_t oscMode
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	logic rdCfg;
	assign rdCfg = hsel && hready && htrans == 2'h2 && !hwrite && haddr == 32'h8;
	chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
	chk_powerup_timer_forced: assert property (brownoutResetEn |-> powerupTimerEn)
		else $error("power-up timer off with brownout on");
	chk_read_allow: assert property (programReadAllowed == (codeProtectLevel == CP_OFF))
		else $error("read allow wrong");
	chk_reset_state: assert property ($rose(reset_n) |-> codeProtectLevel == CP_ALL && dataEepromProtect
		&& powerupTimerEn && !watchdogEn && !brownoutResetEn) else $error("reset settings wrong");
	chk_settings_hold: assert property (reset_n && $past(reset_n) && $past(reset_n, 2) && $past(reset_n, 3)
		|-> $stable({codeProtectLevel, dataEepromProtect, powerupTimerEn, watchdogEn, oscMode, resetPinIsReset,
		brownoutResetEn, programReadAllowed}))
		else $error("settings changed");
	chk_unimpl_ones: assert property (rdCfg && progModePin && $past(progModePin, 4)
		|=> hrdata[13:10] == 4'hf) else $error("unimplemented bits not one");
	chk_read_refused: assert property (rdCfg && !progModePin && !$past(progModePin, 4)
		|=> hrdata == 32'h0) else $error("config read outside program mode");
	cover property (rdCfg && progModePin);
	cover property (brownoutResetEn);
	cover property (oscMode == OSC_RESERVED);
endmodule

// [dv/config_programmer.sv]
// programmer model: ahb-lite master doing single word transfers
// assumes one slave whose hreadyout is hready
`timescale 1ns/1ps
module config_programmer (
	// clock
	input wire logic sys_clk,
	// bus
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic [1:0] htrans,
	output logic [31:0] haddr,
	output logic hwrite,
	output logic [31:0] hwdata
);
	initial begin
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
	end
	task automatic waitRdy();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (n >= 50) config_word_decoder_tb.hang();
	endtask
	// call right after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		waitRdy();
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		q = hrdata;
		// released data lines must not keep the last value
		hwdata <= ~d;
	endtask
endmodule

// [dv/config_word_decoder_tb.sv]
// testbench: programmer model writes, resets and checks decoded settings
// assumes default parameters: two-bit protect, three-bit oscillator
`timescale 1ns/1ps
module config_word_decoder_tb;
	import config_word_pkg::*;
	logic sys_clk = 1'b0, reset_n = 1'b0, progModePin = 1'b1, hsel = 1'b1, hwrite;
	logic [2:0] hsize = 3'h2;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic hready, hreadyout, hresp, programReadAllowed, dataEepromProtect, brownoutResetEn;
	logic powerupTimerEn, resetPinIsReset, watchdogEn;
	cp_level_t codeProtectLevel;
	osc_mode_t oscMode;
	cp_level_t altCp;
	osc_mode_t altOsc;
	logic altReadOk, altDp, altBor, altPwrt, altRst, altWdt;
	int fail_count = 0;
	int tests_run = 0;
	assign hready = hreadyout;
	always #5 sys_clk = ~sys_clk;
	config_word_decoder uut (.*);
	config_programmer prog (.*);
	// variant: one protect bit, two-bit oscillator field, masked program memory
	config_word_decoder #(.SINGLE_CP_BIT(1'b1), .OSC_3BIT(1'b0), .MASKED_ROM(1'b1)) uutAlt (
		.sys_clk(sys_clk), .reset_n(reset_n), .progModePin(progModePin), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(),
		.hreadyout(), .hresp(), .codeProtectLevel(altCp), .programReadAllowed(altReadOk),
		.dataEepromProtect(altDp), .brownoutResetEn(altBor), .powerupTimerEn(altPwrt),
		.resetPinIsReset(altRst), .watchdogEn(altWdt), .oscMode(altOsc));
	function automatic logic [10:0] decode(input logic [13:0] w);
		return {w[6:5], w[6:5] == 2'h3, !w[8], w[7], !w[4] | w[7], w[9], w[3], w[2:0]};
	endfunction
	function automatic logic [10:0] decodeAlt(input logic [13:0] w);
		return {{2{w[5]}}, w[5], !w[5], w[7], !w[4] | w[7], w[9], w[3],
			(w[1:0] == 2'b11) ? 3'b110 : {1'b0, w[1:0]}};
	endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic hang();
		fail_count++;
		stop_test();
	endtask
	task automatic por();
		reset_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
	endtask
	initial begin
		logic [31:0] q;
		logic [13:0] w, c;
		logic [13:0] ids [4];
		void'($urandom(24));
		por();
		for (int i = 0; i < 8; i++) begin
			c = 14'($urandom);
			c[2:0] = 3'(i);
			c[6:5] = i[1:0];
			c[7] = i[2];
			c[4] = i[0];
			prog.xfer(1'b1, 8'h08, {18'h0, c}, q);
			prog.xfer(1'b0, 8'h08, 32'h0, q);
			check("cfg", {18'h0, q[13:0]}, {18'h0, c | 14'h3c00});
			por();
			check("settings", {21'h0, codeProtectLevel, programReadAllowed, dataEepromProtect, brownoutResetEn,
				powerupTimerEn, resetPinIsReset, watchdogEn, oscMode}, {21'h0, decode(c)});
			check("variant", {21'h0, altCp, altReadOk, altDp, altBor, altPwrt, altRst, altWdt, altOsc},
				{21'h0, decodeAlt(c)});
			$display("decode test %0d done", i);
		end
		for (int k = 0; k < 4; k++) begin
			ids[k] = {10'h0, 4'($urandom)};
			prog.xfer(1'b1, 8'h10 + 8'(4 * k), {18'h0, ids[k]}, q);
		end
		for (int k = 0; k < 4; k++) begin
			prog.xfer(1'b0, 8'h10 + 8'(4 * k), 32'h0, q);
			check("uid", {18'h0, q[13:0]}, {18'h0, ids[k]});
		end
		prog.xfer(1'b1, 8'h00, 32'h1, q);
		prog.xfer(1'b0, 8'h04, 32'h0, q);
		check("erased", {31'h0, q[2]}, 32'h1);
		por();
		check("dp erased", {31'h0, dataEepromProtect}, 32'h0);
		prog.xfer(1'b0, 8'h40, 32'h0, q);
		check("unmapped", q, 32'h0);
		$display("id and erase test done");
		progModePin <= 1'b0;
		repeat (5) @(posedge sys_clk);
		prog.xfer(1'b0, 8'h08, 32'h0, q);
		check("cfg run", q, 32'h0);
		prog.xfer(1'b1, 8'h08, 32'h0, q);
		prog.xfer(1'b0, 8'h10, 32'h0, q);
		check("uid run", q, 32'h0);
		progModePin <= 1'b1;
		repeat (5) @(posedge sys_clk);
		prog.xfer(1'b0, 8'h08, 32'h0, q);
		check("cfg kept", {18'h0, q[13:0]}, {18'h0, c | 14'h3c00});
		$display("mode test done");
		stop_test();
	end
endmodule
bind config_word_decoder config_word_decoder_monitor mon (.*);
